// file: rtl/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int CONV_BYPASS_NS  = 660;
  localparam int CONV_AMP_NS     = 1550;
  // longest times, so they round down
  localparam int CONV_BYPASS_CYC = (CONV_BYPASS_NS * CLK_MHZ) / 1000;
  localparam int CONV_AMP_CYC    = (CONV_AMP_NS * CLK_MHZ) / 1000;
  localparam int CNT_W           = 10;

  // ----------------------------------------------------------------
  // data layout
  // ----------------------------------------------------------------
  localparam int DATA_W    = 14;
  localparam int TRAILER_W = 6;
  localparam int SHIFT_W   = DATA_W + TRAILER_W;
  localparam int SYNC_W    = 12;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL_ADDR    = 8'h00;
  localparam logic [7:0]  REG_STATUS_ADDR  = 8'h04;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
  localparam int          CTRL_TRAILER_BIT = 0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------
  // invalid-sample counts
  // ----------------------------------------------------------------
  localparam logic [1:0] SKIP_SEQ_NORMAL  = 2'h2;
  localparam logic [1:0] SKIP_WAKE_NORMAL = 2'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       bypass;
    logic [2:0] gain;
    logic [2:0] chan;
  } sel_t;

  localparam sel_t SEL_RESET = '0;

  typedef enum {CONV_IDLE, CONV_RUN} conv_state_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

endpackage
`default_nettype wire

// file: rtl/adc_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module adc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  // ----------------------------------------------------------------
  // two flops per bit; first stage feeds only the second
  // ----------------------------------------------------------------
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic meta_q;
    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        meta_q    <= 1'b0;
        o_sync[b] <= 1'b0;
      end else begin
        meta_q    <= i_async[b];
        o_sync[b] <= meta_q;
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/adc_axil_regs.sv
`timescale 1ns/100ps
`default_nettype none
module adc_axil_regs (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_srst,
  input  wire adc_ctrl_pkg::axil_req_t i_axil,
  output var  adc_ctrl_pkg::axil_rsp_t o_axil,
  output var  logic [31:0]            o_ctrl,
  input  wire logic [31:0]            i_status
);
  import adc_ctrl_pkg::*;

  logic        aw_have_q, aw_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_have_q, w_have_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;

  // ----------------------------------------------------------------
  // write and read channels
  // ----------------------------------------------------------------
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    ctrl_d    = ctrl_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (i_axil.awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = i_axil.awaddr;
    end
    if (i_axil.wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      w_data_d = i_axil.wdata;
      w_strb_d = i_axil.wstrb;
    end
    if (bvalid_q && i_axil.bready) begin
      bvalid_d = 1'b0;
    end
    // status is read-only; a write there is refused
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_SLVERR;
      if (aw_addr_q == REG_CTRL_ADDR) begin
        bresp_d = RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (w_strb_q[b]) begin
            ctrl_d[8*b +: 8] = w_data_q[8*b +: 8];
          end
        end
      end
    end
    if (rvalid_q && i_axil.rready) begin
      rvalid_d = 1'b0;
    end
    if (i_axil.arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (i_axil.araddr)
        REG_CTRL_ADDR:   rdata_d = ctrl_q;
        REG_STATUS_ADDR: rdata_d = i_status;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      ctrl_q    <= CTRL_RESET;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      ctrl_q    <= ctrl_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  always_comb begin
    o_axil.awready = !aw_have_q;
    o_axil.wready  = !w_have_q;
    o_axil.bvalid  = bvalid_q;
    o_axil.bresp   = bresp_q;
    o_axil.arready = !rvalid_q;
    o_axil.rvalid  = rvalid_q;
    o_axil.rdata   = rdata_q;
    o_axil.rresp   = rresp_q;
    o_ctrl         = ctrl_q;
  end

endmodule
`default_nettype wire

// file: rtl/adc_scan_ctrl.sv
// How it works
// [R1] while scan is on, inputs 0..7 are chosen in turn, repeating
// [R2] normal mode marks the first two samples after scan start invalid
// [R3] input 0 is converted at the second convert-start fall after scan start
// [R4] each later convert-start rise steps the sequencer; 7 wraps to 0
// [R5] gain latched at rise; low power applies it next, normal one later
// [R6] chan_sel is ignored while scan is on and used again after
// [R7] host drops the sample after the first rise seeing scan in low power
// [R8] trailer channel bits report the sequencer choice, not the pins
// [R9] after scan falls one more sequencer input, the next one, is converted
// [R10] gain_sel may change while scanning, sampled at each rise
// [R11] every convert-start fall with power-down released begins a conversion timed by an internal count
// [R12] serial out is off while convert-start is high, driven when low
// [R13] host keeps convert-start low at power-up, power-down and idle
// [R14] power-down during a conversion aborts it and keeps serial out off
// [R15] host drives power-down low when idle with convert-start low
// [R16] after wake, normal mode marks the first sample invalid; low power not
// [R17] undriven power-down pin reads as released through the pad pull-up
// [R18] undriven low-power pin reads as normal mode through the pad pull-down
// [R19] low power starts only after one sample taken with low_power_sel high
// [R20] chan_sel is a 3-bit binary input number, bit 2 most significant
// [R21] gain codes give 1,2,3,4,6,8,12,16; bypass ignores all three gain bits
// [R22] outside scan in normal mode selections apply one sample later
// [R23] trailer shifts three channel bits then three gain bits, msb first
// [R24] a fresh scan start always restarts the sequencer at input 0
// [R25] sequencer position holds while scan is off, moves only at rises
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module adc_scan_ctrl (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_srst,
  input  wire adc_ctrl_pkg::axil_req_t i_axil,
  output var  adc_ctrl_pkg::axil_rsp_t o_axil,
  input  wire logic                    i_conv_start_bar,
  input  wire logic                    i_sequence_enable,
  input  wire logic [2:0]              i_chan_sel,
  input  wire logic [2:0]              i_gain_sel,
  input  wire logic                    i_amp_bypass,
  input  wire logic                    i_powerdown_n,
  input  wire logic                    i_low_power_sel,
  input  wire logic                    i_serial_clk,
  input  wire logic [13:0]             i_core_data,
  output var  logic                    o_sdo,
  output var  logic                    o_sdo_oe,
  output var  logic                    o_core_start,
  output var  adc_ctrl_pkg::sel_t      o_core_sel,
  output var  logic [4:0]              o_gain_factor,
  output var  logic                    o_busy,
  output var  logic                    o_sample_valid
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic              cs_s;
  logic              seq_s;
  logic [2:0]        chan_s;
  logic [2:0]        gain_s;
  logic              byp_s;
  logic              pd_n_s;
  logic              pd_s;
  logic              lpm_s;
  logic              sck_s;

  adc_sync2 #(
    .W (SYNC_W)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_async   ({i_conv_start_bar, i_sequence_enable, i_chan_sel, i_gain_sel,
                 i_amp_bypass, !i_powerdown_n, i_low_power_sel, i_serial_clk}),
    .o_sync    (pins_s)
  );

  // pull-up and pull-down sit in the pads; logic sees resolved levels
  assign {cs_s, seq_s, chan_s, gain_s, byp_s, pd_s, lpm_s, sck_s} = pins_s;
  // power-down rides inverted so a cleared synchroniser reads released: no false wake
  assign pd_n_s = !pd_s;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] status;

  adc_axil_regs u_regs (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_axil    (i_axil),
    .o_axil    (o_axil),
    .o_ctrl    (ctrl),
    .i_status  (status)
  );

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic cs_prev_q, seq_prev_q, sck_prev_q, pd_prev_q;
  logic cs_rise, cs_fall, seq_rise, sck_fall, wake;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cs_prev_q  <= 1'b0;
      seq_prev_q <= 1'b0;
      sck_prev_q <= 1'b0;
      pd_prev_q  <= 1'b1;
    end else begin
      cs_prev_q  <= cs_s;
      seq_prev_q <= seq_s;
      sck_prev_q <= sck_s;
      pd_prev_q  <= pd_n_s;
    end
  end

  assign cs_rise  = cs_s && !cs_prev_q;
  assign cs_fall  = !cs_s && cs_prev_q;
  assign seq_rise = seq_s && !seq_prev_q;
  assign sck_fall = !sck_s && sck_prev_q;
  assign wake     = pd_n_s && !pd_prev_q;

  // ----------------------------------------------------------------
  // sequencer and selection latch
  // ----------------------------------------------------------------
  logic [2:0] seq_pos_q, seq_pos_d;
  logic       armed_q, armed_d;
  logic       restart_q, restart_d;
  logic       lpwait_q, lpwait_d;
  sel_t       lat_q, lat_d;
  sel_t       apply_q, apply_d;
  logic       lpm_active_q;
  logic       seq_own;
  logic [2:0] seq_next;
  sel_t       cand;

  always_comb begin
    seq_own   = seq_s || armed_q;
    seq_next  = seq_pos_q + 3'h1;                        // [R4]
    if (seq_s && (restart_q || !armed_q)) begin
      seq_next = 3'h0;                                   // [R24] [R3]
    end
    cand.chan   = seq_own ? seq_next : chan_s;           // [R6] [R9] [R20]
    cand.bypass = byp_s;
    cand.gain   = byp_s ? 3'h0 : gain_s;                 // [R21] [R10]
    seq_pos_d = seq_pos_q;
    armed_d   = armed_q;
    restart_d = restart_q;
    lpwait_d  = lpwait_q;
    lat_d     = lat_q;
    apply_d   = apply_q;
    if (cs_rise) begin
      if (seq_s) begin
        seq_pos_d = seq_next;                            // [R1] [R25]
        // low power spends its first scan rise on a dropped sample
        restart_d = lpwait_q;                            // [R3]
      end
      lpwait_d = 1'b0;
      // the edge after scan falls spends the last sequencer pick
      armed_d = seq_s;                                   // [R9]
      lat_d   = cand;
      apply_d = lpm_active_q ? cand : lat_q;             // [R5] [R22]
    end
    // a new scan start beats a clear in the same cycle
    if (seq_rise) begin
      restart_d = 1'b1;                                  // [R24]
      lpwait_d  = lpm_active_q;                          // [R3]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      seq_pos_q <= 3'h0;
      armed_q   <= 1'b0;
      restart_q <= 1'b0;
      lpwait_q  <= 1'b0;
      lat_q     <= SEL_RESET;
      apply_q   <= SEL_RESET;
    end else begin
      seq_pos_q <= seq_pos_d;
      armed_q   <= armed_d;
      restart_q <= restart_d;
      lpwait_q  <= lpwait_d;
      lat_q     <= lat_d;
      apply_q   <= apply_d;
    end
  end

  // ----------------------------------------------------------------
  // conversion timing, mode and validity
  // ----------------------------------------------------------------
  conv_state_t  state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  sel_t         conv_sel_q, conv_sel_d;
  logic         lpm_active_d;
  logic [1:0]   skip_q, skip_d;
  logic         valid_q, valid_d;
  logic         start_ok;
  logic         done;
  logic         lpm_catch;

  assign start_ok  = cs_fall && pd_n_s;
  assign lpm_catch = start_ok && lpm_s;
  assign done      = (state_q == CONV_RUN) && (cnt_q == 10'h001) && pd_n_s && !cs_fall;

  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    conv_sel_d   = conv_sel_q;
    lpm_active_d = lpm_active_q;
    skip_d       = skip_q;
    valid_d      = valid_q;
    case (state_q)
      CONV_IDLE: ;
      CONV_RUN: begin
        cnt_d = cnt_q - 10'h001;
        if (cnt_q == 10'h001) begin
          state_d = CONV_IDLE;
        end
      end
      default: state_d = CONV_IDLE;
    endcase
    if (start_ok) begin
      state_d    = CONV_RUN;                             // [R11]
      cnt_d      = apply_q.bypass ? CNT_W'(CONV_BYPASS_CYC) : CNT_W'(CONV_AMP_CYC);
      conv_sel_d = apply_q;
      valid_d    = (skip_q == 2'h0);
      if (skip_q != 2'h0) begin
        skip_d = skip_q - 2'h1;
      end
      lpm_active_d = lpm_s;                              // [R19] [R18]
    end
    if (!lpm_s) begin
      lpm_active_d = 1'b0;                               // [R18]
    end
    if (!pd_n_s) begin
      state_d = CONV_IDLE;                               // [R14] [R17]
    end
    // loading wins over counting down
    if (wake && !lpm_active_q) begin
      skip_d = SKIP_WAKE_NORMAL;                         // [R16]
    end
    if (seq_rise && !lpm_active_q) begin
      skip_d = SKIP_SEQ_NORMAL;                          // [R2]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_q      <= CONV_IDLE;
      cnt_q        <= '0;
      conv_sel_q   <= SEL_RESET;
      lpm_active_q <= 1'b0;
      skip_q       <= 2'h0;
      valid_q      <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      conv_sel_q   <= conv_sel_d;
      lpm_active_q <= lpm_active_d;
      skip_q       <= skip_d;
      valid_q      <= valid_d;
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic [SHIFT_W-1:0] shift_q, shift_d;
  logic               oe_q, oe_d;
  logic [TRAILER_W-1:0] trailer;

  always_comb begin
    // with the trailer off the extra bits shift out as zero
    trailer = ctrl[CTRL_TRAILER_BIT] ? {conv_sel_q.chan, conv_sel_q.gain}
                                     : {TRAILER_W{1'b0}};   // [R8] [R23]
    shift_d = shift_q;
    if (done) begin
      shift_d = {i_core_data, trailer};
    end else if (sck_fall && !cs_s) begin
      shift_d = {shift_q[SHIFT_W-2:0], 1'b0};
    end
    oe_d = !cs_s && pd_n_s;                              // [R12] [R14]
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      shift_q <= '0;
      oe_q    <= 1'b0;
    end else begin
      shift_q <= shift_d;
      oe_q    <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    o_sdo          = shift_q[SHIFT_W-1];
    o_sdo_oe       = oe_q;
    o_core_start   = start_ok;
    o_core_sel     = conv_sel_q;
    o_busy         = (state_q == CONV_RUN);
    o_sample_valid = valid_q;
    case (conv_sel_q.gain)
      3'h0:    o_gain_factor = 5'h01;                    // [R21]
      3'h1:    o_gain_factor = 5'h02;
      3'h2:    o_gain_factor = 5'h03;
      3'h3:    o_gain_factor = 5'h04;
      3'h4:    o_gain_factor = 5'h06;
      3'h5:    o_gain_factor = 5'h08;
      3'h6:    o_gain_factor = 5'h0c;
      default: o_gain_factor = 5'h10;
    endcase
    status = {22'h0, valid_q, lpm_active_q, o_busy, conv_sel_q};
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  AST_SEQ_RESTART: assert property (cs_rise && seq_s && restart_q |=> seq_pos_q == 3'h0) // [R24]
    else $error("scan start did not restart at input 0");
  AST_SEQ_WRAP: assert property (cs_rise && seq_s && armed_q && !restart_q && seq_pos_q == 3'h7
    |=> seq_pos_q == 3'h0 && lat_q.chan == 3'h0) // [R4]
    else $error("sequencer did not wrap after input 7");
  AST_SEQ_HOLD: assert property (!(cs_rise && seq_s) |=> $stable(seq_pos_q)) // [R25]
    else $error("sequencer moved without a rise under scan");
  AST_CHAN_IGNORE: assert property (cs_rise && seq_s |=> lat_q.chan == seq_pos_q) // [R6]
    else $error("pin channel used during scan");
  AST_TAIL: assert property (cs_rise && !seq_s && armed_q
    |=> lat_q.chan == 3'(seq_pos_q + 3'h1) ##1 !armed_q) // [R9]
    else $error("tail sample after scan off wrong");
  AST_SDO_OFF: assert property (cs_s |=> !o_sdo_oe) // [R12]
    else $error("serial out driven while convert-start high");
  AST_PD_ABORT: assert property (!pd_n_s |=> !o_busy && !o_sdo_oe) // [R14]
    else $error("power-down did not abort");
  AST_CONV_LEN: assert property (start_ok ##1 (pd_n_s && !cs_fall)[*8] |-> o_busy[*8]) // [R11]
    else $error("conversion ended too early");
  AST_LPM_ENTRY: assert property ($rose(lpm_active_q) |-> $past(lpm_catch)) // [R19]
    else $error("low power entered without a sample");
  AST_GAIN_LPM: assert property (cs_rise && lpm_active_q |=> apply_q.gain == lat_q.gain) // [R5]
    else $error("low power gain not applied to current sample");
  AST_INIT_SKIP: assert property (seq_rise && !lpm_active_q |=> skip_q == 2'h2) // [R2]
    else $error("scan start did not mark init samples");

endmodule
`default_nettype wire

// file: test/adc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire logic        i_busy,
  input  wire logic        i_sdo,
  input  wire logic        i_sdo_oe,
  output var  logic        o_cs_bar,
  output var  logic        o_sck,
  output var  logic [19:0] o_word,
  output var  logic        o_done
);
  // ----------------------------------------
  // one sample per toggle of i_go
  // ----------------------------------------
  initial begin
    o_cs_bar = 1'b0;
    o_sck    = 1'b0;
    o_word   = '0;
    o_done   = 1'b0;
  end
  always @(i_go) begin
    @(posedge i_sys_clk) o_cs_bar <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    o_cs_bar <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    while (i_busy === 1'b1) @(posedge i_sys_clk);
    // sck stands still outside frames; a released line reads as junk
    for (int k = 0; k < 20; k++) begin
      #32 o_sck = 1'b1;
      o_word = {o_word[18:0], i_sdo_oe ? i_sdo : ~o_word[0]};
      #32 o_sck = 1'b0;
    end
    @(posedge i_sys_clk) o_done <= i_go;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adc_ctrl_pkg::*;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  typedef struct packed {
    logic       s;
    logic [2:0] c, g, ec, eg;
    logic       ev, cv, ck;
  } row_t;
  localparam row_t ROWS [15] = '{
    '{0,5,1,0,0,0,0,0}, '{0,2,3,5,1,0,0,1}, '{1,7,4,2,3,0,1,1},
    '{1,7,5,0,4,0,1,1}, '{1,0,6,1,5,1,1,1}, '{1,1,7,2,6,1,1,1},
    '{1,2,0,3,7,1,1,1}, '{1,3,1,4,0,1,1,1}, '{1,4,2,5,1,1,1,1},
    '{1,5,3,6,2,1,1,1}, '{1,6,4,7,3,1,1,1}, '{1,0,5,0,4,1,1,1},
    '{0,4,6,1,5,1,1,1}, '{0,6,7,2,6,1,1,1}, '{0,3,0,6,7,1,1,1}};
  localparam logic [4:0] GFAC [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10};
  logic        clk = 1'b0, srst = 1'b1, scan = 1'b0, go = 1'b0;
  logic        pd = 1'b1;
  logic        lp = 1'b0;
  logic        byp = 1'b0;
  logic [2:0]  ch = 3'h0, gn = 3'h0;
  logic [13:0] cd = 14'h0000;
  logic [31:0] rd;
  logic [1:0]  rr;
  axil_req_t   ax = '0;
  axil_rsp_t   rs;
  sel_t        sel;
  logic [4:0]  gf;
  logic [19:0] word;
  logic        cs_bar, sck, sdo, oe, busy, sv, done, cstart;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  int          busy_len = 0, last_len = 0, starts = 0;
  always #2.5 clk = ~clk;
  // conversion length in cycles and number of conversion starts
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end else if (busy_len != 0) begin
      last_len <= busy_len;
      busy_len <= 0;
    end
    if (cstart === 1'b1) starts <= starts + 1;
  end
  adc_scan_ctrl DUT (.i_sys_clk(clk), .i_srst(srst), .i_axil(ax), .o_axil(rs),
    .i_conv_start_bar(cs_bar), .i_sequence_enable(scan), .i_chan_sel(ch), .i_gain_sel(gn),
    .i_amp_bypass(byp), .i_powerdown_n(pd), .i_low_power_sel(lp), .i_serial_clk(sck),
    .i_core_data(cd), .o_sdo(sdo), .o_sdo_oe(oe), .o_core_start(cstart), .o_core_sel(sel),
    .o_gain_factor(gf), .o_busy(busy), .o_sample_valid(sv));
  adc_host_model host (.i_sys_clk(clk), .i_go(go), .i_busy(busy), .i_sdo(sdo),
    .i_sdo_oe(oe), .o_cs_bar(cs_bar), .o_sck(sck), .o_word(word), .o_done(done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ax.awaddr  <= a;
    ax.wdata   <= d;
    ax.wstrb   <= 4'hf;
    ax.awvalid <= 1'b1;
    ax.wvalid  <= 1'b1;
    ax.bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.awready) ax.awvalid <= 1'b0;
      if (rs.wready) ax.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1);
    rr = rs.bresp;
    ax.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    ax.araddr  <= a;
    ax.arvalid <= 1'b1;
    ax.rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.arready) ax.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1);
    rd = rs.rdata;
    rr = rs.rresp;
    ax.rready <= 1'b0;
  endtask
  // pins settle well before the host raises convert-start
  task automatic smp(input logic s, input logic [2:0] c, input logic [2:0] g,
                     input logic [13:0] d);
    scan <= s;
    ch   <= c;
    gn   <= g;
    cd   <= d;
    repeat (5) @(posedge clk);
    go <= ~go;
    do @(posedge clk); while (done !== go);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      complete_run;
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    chk(oe, 0);
    chk(busy, 0);
    chk(sel, 0);
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdr(REG_CTRL_ADDR);
    chk(rd, CTRL_RESET);
    chk(rr, RESP_OKAY);
    for (int i = 0; i < 15; i++) begin
      smp(ROWS[i].s, ROWS[i].c, ROWS[i].g, 14'(i * 291));
      if (ROWS[i].ck) begin
        chk(sel.chan, ROWS[i].ec);
        chk(sel.gain, ROWS[i].eg);
        chk(gf, GFAC[ROWS[i].eg]);
        chk(word, {cd, ROWS[i].ec, ROWS[i].eg});
        chk(oe, 1);
        chk(last_len, CONV_AMP_CYC);
      end
      if (ROWS[i].cv) chk(sv, ROWS[i].ev);
      $display("row %0d done", i);
    end
    go <= ~go;
    do @(posedge clk); while (busy !== 1'b1);
    pd <= 1'b0;
    repeat (8) @(posedge clk);
    chk(busy, 0);
    chk(oe, 0);
    do @(posedge clk); while (done !== go);
    pd <= 1'b1;
    smp(0, 1, 2, 14'h1111);
    chk(sv, 0);
    smp(0, 1, 2, 14'h2222);
    chk(sv, 1);
    $display("power-down test done");
    lp <= 1'b1;
    smp(0, 4, 6, 14'h0abc);
    smp(0, 3, 7, 14'h0def);
    chk(sel, {1'b0, 3'h7, 3'h3});
    rdr(REG_STATUS_ADDR);
    chk(rd & 32'h0000_017f, 32'h0000_013b);
    $display("low power test done");
    wr(REG_CTRL_ADDR, 32'h0000_0000);
    chk(rr, RESP_OKAY);
    smp(0, 3, 7, 14'h0123);
    chk(word, {14'h0123, 6'h00});
    wr(REG_STATUS_ADDR, 32'hffff_ffff);
    chk(rr, RESP_SLVERR);
    rdr(8'h08);
    chk(rd, 0);
    chk(rr, RESP_SLVERR);
    $display("register test done");
    smp(1, 5, 1, 14'h0555); // low-power scan start: the host reads this sample but nothing checks it
    smp(1, 5, 1, 14'h0666);
    chk(sel, {1'b0, 3'h1, 3'h0});
    byp <= 1'b1;
    smp(1, 5, 7, 14'h0777);
    chk(sel, {1'b1, 3'h0, 3'h1});
    chk(gf, 5'h01);
    chk(last_len, CONV_BYPASS_CYC);
    chk(starts, 24);
    $display("low power scan test done");
    complete_run;
  end
endmodule
`default_nettype wire
